// File: design/hbp_defs.svh
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH
// strap code for processor mode and software base pattern
`define HBP_STRAP_CPU      4'h0
`define HBP_SW_PATTERN     6'b010101
// even and odd location select
`define HBP_ADDR_MASK      10'h3fe
// fifo function codes
`define HBP_FN_Z1_LO       4'h0
`define HBP_FN_Z1_HI       4'h1
`define HBP_FN_Z2_LO       4'h2
`define HBP_FN_Z2_HI       4'h3
`define HBP_FN_INC_F1      4'ha
`define HBP_FN_WR_DATA     4'hb
`define HBP_FN_RD_F1       4'hc
`define HBP_FN_RD_F2       4'hd
`define HBP_FN_INC_F2      4'he
`define HBP_FN_RD_DATA     4'hf
// signalling fifo codes occupy 0x10..0x27 with one fifo bit
`define HBP_D_FIRST        8'h10
`define HBP_D_LAST         8'h27
// host strobe length in clocks; covers the device's two-flop path and the reply
`define HBP_STROBE_CYCLES  7
`endif

// File: design/hbp_pkg.sv
`default_nettype none
package hbp_pkg;
	typedef enum logic [1:0] {HBP_ISA, HBP_STROBE_DIR, HBP_SEP_STROBE, HBP_MUX} hbp_mode_e;
	typedef enum logic [3:0] {
		HBP_OP_NONE, HBP_OP_RD_ZCNT, HBP_OP_SELECT, HBP_OP_INC_F1, HBP_OP_WR_DATA,
		HBP_OP_WR_REV, HBP_OP_RD_F1, HBP_OP_RD_F2, HBP_OP_INC_F2, HBP_OP_RD_DATA,
		HBP_OP_RD_REV, HBP_OP_REG
	} hbp_op_e;
	typedef logic [7:0] hbp_byte_t;
endpackage
`default_nettype wire

// File: design/hbp_bus_if.sv
`default_nettype none
interface hbp_bus_if;
	logic [9:0] sa;
	logic       aen_cs_n;
	logic       ior_ds_n;
	logic       iow_rw_n;
	logic       ale;
	logic [7:0] bd_host;
	logic       bd_host_oe;
	logic [7:0] bd_dev;
	logic       bd_dev_oe;
	logic       buffer_direction;
	modport dev  (input sa, aen_cs_n, ior_ds_n, iow_rw_n, ale, bd_host, bd_host_oe,
		output bd_dev, bd_dev_oe, buffer_direction);
	modport host (output sa, aen_cs_n, ior_ds_n, iow_rw_n, ale, bd_host, bd_host_oe,
		input bd_dev, bd_dev_oe, buffer_direction);
endinterface
`default_nettype wire

// File: design/hbp_host_end.sv
`include "hbp_defs.svh"
`default_nettype none
// host end: runs one bus cycle per request in the mode given by cpu_mode
module hbp_host_end
	import hbp_pkg::*;
#(
	parameter int STROBE_CYCLES = `HBP_STROBE_CYCLES
)
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	hbp_bus_if.host         bus,
	input  wire hbp_mode_e  cpu_mode,
	input  wire logic       req,
	input  wire logic       req_write,
	input  wire logic [9:0] req_addr,
	input  wire logic [7:0] req_wdata,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rdata
);
	typedef enum {HS_IDLE, HS_ADDR, HS_STROBE, HS_HOLD, HS_END} hbp_hst_e;
	hbp_hst_e   state;
	logic       wr;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic [7:0] bd_s1;
	logic [7:0] bd_s2;
	logic [3:0] strobe_cnt;

	// the reply needs six clocks to come back through both synchronisers
	if (STROBE_CYCLES < 6 || STROBE_CYCLES > 15)
	begin : g_bad_strobe
		$error("strobe length out of range");
	end

	// bus read data passes two flops; a released bus floats high
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			bd_s1 <= 8'h00;
			bd_s2 <= 8'h00;
		end
		else
		begin
			bd_s1 <= bus.bd_dev_oe ? bus.bd_dev : 8'hff;
			bd_s2 <= bd_s1;
		end

	// cycle sequencer
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			state <= HS_IDLE;
			wr    <= 1'b0;
			addr  <= 10'h000;
			wdata <= 8'h00;
			done  <= 1'b0;
			rdata <= 8'h00;
			strobe_cnt <= 4'h0;
		end
		else
		begin
			done <= 1'b0;
			case (state)
				HS_IDLE:
					if (req)
					begin
						wr    <= req_write;
						addr  <= req_addr;
						wdata <= req_wdata;
						state <= HS_ADDR;
					end
				HS_ADDR:
				begin
					strobe_cnt <= 4'h0;
					state      <= HS_STROBE;
				end
				// strobe stays low until the device answer has crossed back
				HS_STROBE:
					if (strobe_cnt == 4'(STROBE_CYCLES - 2))
						state <= HS_HOLD;
					else
						strobe_cnt <= strobe_cnt + 4'h1;
				HS_HOLD:
				begin
					if (!wr)
						rdata <= bd_s2;
					state <= HS_END;
				end
				HS_END:
				begin
					done  <= 1'b1;
					state <= HS_IDLE;
				end
				default:   state <= HS_IDLE;
			endcase
		end

	assign busy = (state != HS_IDLE);

	// pin drive; isa keeps ale low, ale constant except mux mode
	always_comb
	begin
		bus.sa         = addr;
		bus.bd_host    = wdata;
		bus.bd_host_oe = 1'b0;
		bus.aen_cs_n   = 1'b1;
		bus.ior_ds_n   = 1'b1;
		bus.iow_rw_n   = 1'b1;
		bus.ale        = (cpu_mode == HBP_STROBE_DIR);
		if (state == HS_ADDR || state == HS_STROBE || state == HS_HOLD)
		begin
			bus.aen_cs_n = (cpu_mode == HBP_ISA) ? 1'b0 : (state == HS_ADDR);
			if (cpu_mode == HBP_MUX && state == HS_ADDR)
			begin
				// ale pulse with address on the data lines
				bus.ale        = 1'b1;
				bus.bd_host    = addr[7:0];
				bus.bd_host_oe = 1'b1;
			end
			else if (state != HS_ADDR)
			begin
				bus.bd_host_oe = wr;
				if (cpu_mode == HBP_STROBE_DIR)
				begin
					bus.iow_rw_n = ~wr;
					bus.ior_ds_n = 1'b0;
				end
				else
				begin
					bus.ior_ds_n = wr;
					bus.iow_rw_n = ~wr;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: design/hbp_dev_end.sv
// Operation
// - isa claims two addresses, nine bits compared
// - reset starts at strap-chosen base
// - strap code picks base; zero means processor
// - host writes low base byte at even
// - odd write with pattern switches to software base
// - switched device answers only new pair
// - aen or idle strobes mean no access
// - isa board holds ale low, strap nonzero
// - direction high into device, low on read except isa before software base
// - processor mode decodes 256 addresses
// - strobe mode: direction chooses read or write
// - separate strobes; ale pulse latches address
// - ale constant except multiplexed mode
// - odd control write loads register pointer
// - processor mode selects register from address
// - fifo address is function code plus select
// - framed codes map counters and data
// - transparent codes reverse bits on b channels
// - fifo change takes effect after busy phase
// - counter-low write only selects the fifo
`include "hbp_defs.svh"
`default_nettype none
module hbp_dev_end
	import hbp_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	hbp_bus_if.dev          bus,
	input  wire logic [3:0] strap_base_select,
	input  wire logic       busy_phase,
	input  wire logic [1:0] transparent,
	input  wire logic [7:0] reg_rdata,
	input  wire logic [7:0] status_rdata,
	output hbp_mode_e       mode,
	output logic            soft_base_mode,
	output logic [7:0]      register_pointer,
	output logic            acc_strobe,
	output logic            acc_write,
	output logic [7:0]      acc_addr,
	output hbp_op_e         acc_op,
	output logic [7:0]      acc_wdata,
	output logic [2:0]      fifo_select,
	output logic [2:0]      fifo_pending
);
	// synchronised pins
	logic [9:0] sa_s1, sa_s2;
	logic [7:0] bd_s1, bd_s2;
	logic [3:0] ctl_s1, ctl_s2;
	logic [3:0] strap_s1, strap_s2;
	logic       cs_n, rd_n, wr_n, ale;
	logic       started;
	logic [1:0] warm;
	logic [9:0] base;
	logic [7:0] lo_byte;
	logic [7:0] mux_addr;
	logic       hit, rd_act, wr_act, rd_q, wr_q;
	logic       busy_q;

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			sa_s1 <= 10'h000;
			sa_s2 <= 10'h000;
			bd_s1 <= 8'h00;
			bd_s2 <= 8'h00;
			ctl_s1 <= 4'hf;
			ctl_s2 <= 4'hf;
			strap_s1 <= 4'h0;
			strap_s2 <= 4'h0;
		end
		else
		begin
			sa_s1 <= bus.sa;
			sa_s2 <= sa_s1;
			bd_s1 <= bus.bd_host;
			bd_s2 <= bd_s1;
			ctl_s1 <= {bus.aen_cs_n, bus.ior_ds_n, bus.iow_rw_n, ~bus.ale};
			ctl_s2 <= ctl_s1;
			strap_s1 <= strap_base_select;
			strap_s2 <= strap_s1;
		end

	assign cs_n = ctl_s2[3];
	assign ale  = ~ctl_s2[0];

	// strap table lookup
	function automatic logic [9:0] strap_base(input logic [3:0] code);
		case (code)
			4'h1: strap_base = 10'h2e0;
			4'h2: strap_base = 10'h2d0;
			4'h3: strap_base = 10'h210;
			4'h4: strap_base = 10'h2c0;
			4'h5: strap_base = 10'h200;
			4'h6: strap_base = 10'h2f8;
			4'h7: strap_base = 10'h2e8;
			4'h8: strap_base = 10'h2b0;
			4'h9: strap_base = 10'h3e0;
			4'ha: strap_base = 10'h320;
			4'hb: strap_base = 10'h278;
			4'hc: strap_base = 10'h310;
			4'hd: strap_base = 10'h330;
			4'he: strap_base = 10'h300;
			4'hf: strap_base = 10'h3e8;
			default: strap_base = 10'h000;
		endcase
	endfunction

	// mode and base caught once the synchronisers hold pin values
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			warm    <= 2'd0;
			started <= 1'b0;
			mode    <= HBP_ISA;
		end
		else if (!started)
		begin
			if (warm != 2'd2)
				warm <= warm + 2'd1;
			else
			begin
				started <= 1'b1;
				if (strap_s2 != `HBP_STRAP_CPU)
					mode <= HBP_ISA;
				else
					mode <= ale ? HBP_STROBE_DIR : HBP_SEP_STROBE;
			end
		end
		else if ((mode == HBP_SEP_STROBE) && ale)
			mode <= HBP_MUX; // ale pulse marks multiplexed bus

	// strobe decode per mode
	always_comb
	begin
		rd_n = ctl_s2[2];
		wr_n = ctl_s2[1];
		if (mode == HBP_STROBE_DIR)
		begin
			rd_n = ctl_s2[2] | ~ctl_s2[1];
			wr_n = ctl_s2[2] | ctl_s2[1];
		end
	end

	assign hit = (mode != HBP_ISA) ||
		((sa_s2 & `HBP_ADDR_MASK) == (base & `HBP_ADDR_MASK));
	// no access with aen high or both strobes idle
	assign rd_act = started && !cs_n && !rd_n && hit && (mode == HBP_ISA ? !ale : 1'b1);
	assign wr_act = started && !cs_n && !wr_n && hit && (mode == HBP_ISA ? !ale : 1'b1);

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			mux_addr <= 8'h00;
		else if (ale)
			mux_addr <= bd_s2;

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			base             <= 10'h000;
			soft_base_mode   <= 1'b0;
			lo_byte          <= 8'h00;
			register_pointer <= 8'h00;
		end
		else if (!started)
			base <= strap_base(strap_s2);
		else if (wr_act && !wr_q && mode == HBP_ISA)
		begin
			if (!soft_base_mode && !sa_s2[0])
				lo_byte <= bd_s2;
			else if (!soft_base_mode && bd_s2[7:2] == `HBP_SW_PATTERN)
			begin
				base           <= {bd_s2[1:0], lo_byte[7:1], 1'b0};
				soft_base_mode <= 1'b1;
			end
			else if (soft_base_mode && sa_s2[0])
				register_pointer <= bd_s2;
		end

	// register address: pointer in isa, latched data lines in mux, address lines otherwise
	always_comb
	begin
		if (mode == HBP_ISA)
			acc_addr = register_pointer;
		else if (mode == HBP_MUX)
			acc_addr = mux_addr;
		else
			acc_addr = sa_s2[7:0];
	end

	always_comb
	begin
		logic [3:0] fn;
		logic       is_d;
		logic       is_fifo;
		fn      = acc_addr[5:2];
		is_d    = (acc_addr >= `HBP_D_FIRST) && (acc_addr <= `HBP_D_LAST) && !acc_addr[7];
		is_fifo = (acc_addr[7:6] == 2'b10);
		// signalling fifo: five-bit code mapped onto the bearer function codes
		if (is_d)
		begin
			is_fifo = 1'b1;
			case (acc_addr[5:1])
				5'h08: fn = `HBP_FN_Z1_LO;
				5'h0a: fn = `HBP_FN_Z1_HI;
				5'h0c: fn = `HBP_FN_Z2_LO;
				5'h0e: fn = `HBP_FN_Z2_HI;
				5'h09: fn = `HBP_FN_INC_F1;
				5'h0b: fn = `HBP_FN_WR_DATA;
				5'h0d: fn = `HBP_FN_RD_F1;
				5'h0f: fn = `HBP_FN_RD_F2;
				5'h11: fn = `HBP_FN_INC_F2;
				5'h13: fn = `HBP_FN_RD_DATA;
				default: is_fifo = 1'b0;
			endcase
		end
		acc_op = HBP_OP_REG;
		if (is_fifo)
		case (fn)
			// a write to the input counter only selects
			`HBP_FN_Z1_LO, `HBP_FN_Z1_HI: acc_op = wr_act ? HBP_OP_SELECT : HBP_OP_RD_ZCNT;
			`HBP_FN_Z2_LO, `HBP_FN_Z2_HI: acc_op = HBP_OP_RD_ZCNT;
			`HBP_FN_INC_F1: acc_op = (transparent[acc_addr[1]] && !is_d) ? HBP_OP_WR_REV
				: HBP_OP_INC_F1;
			`HBP_FN_WR_DATA: acc_op = HBP_OP_WR_DATA;
			`HBP_FN_RD_F1: acc_op = HBP_OP_RD_F1;
			`HBP_FN_RD_F2: acc_op = HBP_OP_RD_F2;
			`HBP_FN_INC_F2: acc_op = (transparent[acc_addr[1]] && !is_d) ? HBP_OP_RD_REV
				: HBP_OP_INC_F2;
			`HBP_FN_RD_DATA: acc_op = HBP_OP_RD_DATA;
			default: acc_op = HBP_OP_REG;
		endcase
		if (mode == HBP_ISA && sa_s2[0])
			acc_op = HBP_OP_NONE;
	end

	// one strobe per access, data bit-reversed when asked
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			rd_q       <= 1'b0;
			wr_q       <= 1'b0;
			acc_strobe <= 1'b0;
			acc_write  <= 1'b0;
			acc_wdata  <= 8'h00;
		end
		else
		begin
			rd_q       <= rd_act;
			wr_q       <= wr_act;
			acc_strobe <= ((rd_act && !rd_q) || (wr_act && !wr_q)) && soft_or_cpu();
			acc_write  <= wr_act;
			acc_wdata  <= (acc_op == HBP_OP_WR_REV) ? {<<{bd_s2}} : bd_s2;
		end

	function automatic logic soft_or_cpu();
		soft_or_cpu = (mode != HBP_ISA) || (soft_base_mode && !sa_s2[0]);
	endfunction

	// select pending until a busy phase ends; counter untouched
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			busy_q       <= 1'b0;
			fifo_pending <= 3'h0;
			fifo_select  <= 3'h0;
		end
		else
		begin
			busy_q <= busy_phase;
			if (wr_act && !wr_q && acc_op == HBP_OP_SELECT && !busy_phase)
				fifo_pending <= {acc_addr[7:6] != 2'b10, acc_addr[1:0]};
			if (busy_q && !busy_phase)
				fifo_select <= fifo_pending;
		end

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			bus.bd_dev <= 8'h00;
			bus.bd_dev_oe <= 1'b0;
			bus.buffer_direction <= 1'b1;
		end
		else
		begin
			bus.bd_dev_oe <= rd_act && (mode != HBP_ISA || soft_base_mode);
			bus.buffer_direction <= !(rd_act && (mode != HBP_ISA || soft_base_mode));
			if (!rd_act)
				bus.bd_dev <= 8'h00;
			else if (mode == HBP_ISA && sa_s2[0])
				bus.bd_dev <= status_rdata;
			else if (acc_op == HBP_OP_RD_REV)
				bus.bd_dev <= {<<{reg_rdata}};
			else
				bus.bd_dev <= reg_rdata;
		end
endmodule
`default_nettype wire

// File: test/hbp_if_monitor.sv
`default_nettype none
// watches the wires between the host end and the device end
module hbp_if_monitor
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic aen_cs_n,
	input wire logic ior_ds_n,
	input wire logic iow_rw_n,
	input wire logic bd_dev_oe,
	input wire logic buffer_direction
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       rd;
	logic       wr;
	logic [3:0] rd_age;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// read and write cycles as seen on the wires
	assign rd = !aen_cs_n && !ior_ds_n && iow_rw_n;
	assign wr = !aen_cs_n && !iow_rw_n;
	// cycles since the last read, saturating at 15
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			rd_age <= 4'hf;
		else if (rd)
			rd_age <= 4'h0;
		else if (rd_age != 4'hf)
			rd_age <= rd_age + 4'h1;
	property p_dir_low_on_drive; bd_dev_oe |-> !buffer_direction; endproperty
	a_dir_low_on_drive: assert property (p_dir_low_on_drive)
		else $error("direction high while device drives");
	property p_dir_needs_read; !buffer_direction |-> (rd || rd_age <= 4'h6); endproperty
	a_dir_needs_read: assert property (p_dir_needs_read)
		else $error("direction low without a read");
	property p_oe_needs_read; bd_dev_oe |-> (rd || rd_age <= 4'h6); endproperty
	a_oe_needs_read: assert property (p_oe_needs_read)
		else $error("device drives without a read");
	property p_dir_high_idle; rd_age == 4'hf |-> buffer_direction; endproperty
	a_dir_high_idle: assert property (p_dir_high_idle)
		else $error("direction low while idle");
	property p_no_oe_unselected; aen_cs_n [*8] |-> !bd_dev_oe; endproperty
	a_no_oe_unselected: assert property (p_no_oe_unselected)
		else $error("device drives while unselected");
	property p_write_no_drive; wr && rd_age == 4'hf |-> !bd_dev_oe ##1 !bd_dev_oe; endproperty
	a_write_no_drive: assert property (p_write_no_drive)
		else $error("device drives during a write");
	property p_dir_high_write; wr && rd_age == 4'hf |-> buffer_direction [*3]; endproperty
	a_dir_high_write: assert property (p_dir_high_write)
		else $error("direction low during a write");
	property p_reset_quiet; $rose(rst_b) |-> !bd_dev_oe && buffer_direction; endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("bus not released after reset");
	c_read: cover property (rd ##1 rd);
	c_write: cover property (wr);
	c_drive: cover property ($rose(bd_dev_oe));
endmodule
`default_nettype wire

// File: test/tb.sv
`default_nettype none
module tb
	import hbp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk = 1'b0;
	logic       rst_b = 1'b0;
	logic [3:0] strap = 4'h1;
	hbp_mode_e  cpu_mode = HBP_ISA;
	logic       req = 1'b0;
	logic       req_write = 1'b0;
	logic [9:0] req_addr = 10'h000;
	logic [7:0] req_wdata = 8'h00;
	logic       busy_phase = 1'b0;
	logic [7:0] reg_rdata = 8'h00;
	logic [7:0] status_rdata = 8'h00;
	logic [1:0] transparent = 2'b00;
	logic       busy, done, soft_base_mode, acc_strobe, acc_write, got_write;
	logic [7:0] rdata, register_pointer, acc_addr, acc_wdata, got_addr, got_data;
	logic [2:0] fifo_select, fifo_pending;
	hbp_mode_e  mode;
	hbp_op_e    acc_op, got_op;
	int         failures = 0;
	int         tests_run = 0;
	hbp_bus_if bus_if ();
	hbp_host_end hbp_host_end_inst (.mclk, .rst_b, .bus(bus_if), .cpu_mode, .req, .req_write,
		.req_addr, .req_wdata, .busy, .done, .rdata);
	hbp_dev_end hbp_dev_end_inst (.mclk, .rst_b, .bus(bus_if), .strap_base_select(strap),
		.busy_phase, .transparent, .reg_rdata, .status_rdata, .mode, .soft_base_mode,
		.register_pointer, .acc_strobe, .acc_write, .acc_addr, .acc_op, .acc_wdata,
		.fifo_select, .fifo_pending);
	hbp_if_monitor hbp_if_monitor_inst (.mclk, .rst_b, .aen_cs_n(bus_if.aen_cs_n),
		.ior_ds_n(bus_if.ior_ds_n), .iow_rw_n(bus_if.iow_rw_n), .bd_dev_oe(bus_if.bd_dev_oe),
		.buffer_direction(bus_if.buffer_direction));
	// 20 MHz clock
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	// keep the last access handed to the core
	always @(posedge mclk)
		if (acc_strobe === 1'b1)
		begin
			got_write = acc_write;
			got_addr = acc_addr;
			got_data = acc_wdata;
			got_op = acc_op;
		end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic rst_dut(input logic [3:0] s, input hbp_mode_e m);
		rst_b <= 1'b0;
		strap <= s;
		cpu_mode <= m;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
	// one host bus cycle, then room for the device path to settle
	task automatic cyc(input logic w, input logic [9:0] a, input logic [7:0] d);
		int i;
		got_write = 1'b0;
		got_addr = 8'h00;
		got_data = 8'h00;
		req <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge mclk);
		req <= 1'b0;
		@(negedge mclk);
		chk(8'(busy), 8'h01, "host busy");
		for (i = 0; i < 20 && done !== 1'b1; i++)
			@(negedge mclk);
		chk(8'(done), 8'h01, "cycle done");
		repeat (6) @(posedge mclk);
	endtask
	// two reads in a row; each must bring back the answer
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		cyc(1'b0, a, 8'h00);
		chk(rdata, exp, "read data");
		cyc(1'b0, a, 8'h00);
		chk(rdata, exp, "read again");
	endtask
	task automatic t_rev;
		transparent <= 2'b01;
		cyc(1'b1, 10'h0a8, 8'h01);
		chk(8'(got_op), 8'(HBP_OP_WR_REV), "reversed write op");
		chk(got_data, 8'h80, "reversed write data");
		reg_rdata <= 8'h03;
		rd(10'h0b8, 8'hc0);
		cyc(1'b1, 10'h0ac, 8'h01);
		chk(got_data, 8'h01, "plain write data");
		transparent <= 2'b00;
		$display("reverse test done");
	endtask
	task automatic t_isa;
		rst_dut(4'h1, HBP_ISA);
		chk(8'(soft_base_mode), 8'h00, "hw base");
		chk(8'(mode), 8'(HBP_ISA), "isa mode");
		cyc(1'b1, 10'h2e0, 8'ha5);
		cyc(1'b1, 10'h2e1, 8'h97);
		chk(8'(soft_base_mode), 8'h00, "bad pattern");
		cyc(1'b1, 10'h2e1, 8'h57);
		chk(8'(soft_base_mode), 8'h01, "sw base");
		cyc(1'b1, 10'h3a5, 8'h1b);
		chk(register_pointer, 8'h1b, "pointer");
		cyc(1'b1, 10'h2e1, 8'h33);
		cyc(1'b1, 10'h3a7, 8'h44);
		chk(register_pointer, 8'h1b, "foreign pair");
		cyc(1'b1, 10'h3a4, 8'h5a);
		chk(got_addr, 8'h1b, "data target");
		chk(got_data, 8'h5a, "data byte");
		chk(8'(got_write), 8'h01, "data write");
		reg_rdata <= 8'hc3;
		status_rdata <= 8'h96;
		rd(10'h3a4, 8'hc3);
		rd(10'h3a5, 8'h96);
		$display("isa test done");
	endtask
	task automatic t_cpu(input hbp_mode_e m);
		rst_dut(4'h0, m);
		cyc(1'b1, 10'h02e, 8'h3c);
		chk(8'(mode), 8'(m), "bus mode");
		chk(got_addr, 8'h2e, "direct address");
		chk(got_data, 8'h3c, "direct data");
		chk(8'(got_write), 8'h01, "direct write");
		chk(register_pointer, 8'h00, "pointer idle");
		reg_rdata <= 8'h5e;
		rd(10'h0fe, 8'h5e);
		$display("processor test done");
	endtask
	task automatic t_select;
		cyc(1'b1, 10'h011, 8'h77);
		chk(8'(got_op), 8'(HBP_OP_SELECT), "select only");
		chk(8'(fifo_select), 8'h00, "not yet active");
		chk(8'(fifo_pending), 8'h05, "select pending");
		busy_phase <= 1'b1;
		repeat (3) @(posedge mclk);
		busy_phase <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(8'(fifo_select), 8'h05, "fifo active");
		$display("select test done");
	endtask
	initial
	begin
		t_isa();
		t_cpu(HBP_STROBE_DIR);
		t_cpu(HBP_SEP_STROBE);
		t_select();
		t_rev();
		t_cpu(HBP_MUX);
		complete_run();
	end
	// cuts a hang short
	initial
	begin
		repeat (4000) @(posedge mclk);
		failures++;
		complete_run();
	end
endmodule
`default_nettype wire
